// File: core/id_conv_ctrl.sv
`timescale 1ns/10ps
module id_conv_ctrl
  import ident_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Request from the core
  input  wire logic       start_in,
  // Converter handshake
  input  wire logic       conv_done_in,
  input  wire conv_code_t conv_code_in,
  output logic            conv_enable_out,
  // Result
  output logic            done_out,
  output conv_code_t      code_out
);

  // ==================================================
  // One conversion per request; enable drops by itself
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      conv_enable_out <= 1'b0;
    end else if (conv_enable_out && conv_done_in) begin
      conv_enable_out <= 1'b0; // R17
    end else if (start_in) begin
      conv_enable_out <= 1'b1; // R16
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      done_out <= 1'b0;
      code_out <= 5'h00;
    end else begin
      done_out <= conv_enable_out && conv_done_in;
      if (conv_enable_out && conv_done_in) begin
        code_out <= conv_code_in;
      end
    end
  end

endmodule : id_conv_ctrl

// File: core/key_hold_timer.sv
`timescale 1ns/10ps
module key_hold_timer #(
  parameter int unsigned CYCLES = 60000000
) (
  // Clock and reset
  input  wire logic clk_in,
  input  wire logic rst_in,
  // Control
  input  wire logic start_in,
  input  wire logic run_in,
  // Status
  output logic      expired_out
);

  logic [25:0] count_reg;

  // ==================================================
  // Saturating hold counter
  always_ff @(posedge clk_in) begin
    if (rst_in || start_in) begin
      count_reg   <= 26'h0;
      expired_out <= 1'b0;
    end else if (run_in && !expired_out) begin
      count_reg   <= count_reg + 26'h1;
      expired_out <= (count_reg == 26'(CYCLES - 1)); // R21
    end
  end

endmodule : key_hold_timer

// File: core/mode_ident_core.sv
// Contract
// R01: Reset flag sets on power-on, io supply fall or I2C reset; read clears it.
// R02: Mode bits power-save,active: 00 standby, 01 active, 11 power save.
// R03: Mode bits are read/write; writing 0x00 forces standby.
// R04: After forced standby an attached accessory restarts identification.
// R05: Supply absent with VBUS: switch on, charge level high-z, registers reset.
// R06: VBUS only: no identification, charge level stays high-z.
// R07: Supply up with VBUS present: standby then straight into VBUS detection.
// R08: Power-on reset clears registers; switch stays on if VBUS present.
// R09: Supply up without VBUS: reset, standby, switch off, await attachment.
// R10: Standby watches ID and VBUS; either attachment starts identification.
// R11: Conclusion sets device-type bit and attach interrupt.
// R12: Unidentified accessory sets unknown-accessory interrupt.
// R13: ID-open flag clears below 1 megohm and sets when removed.
// R14: ID-open fall starts identification; rise starts detachment. The code detaches on the rise only while VBUS is absent.
// R15: Identification end raises the ident-done signal.
// R16: ID-open clear requests one 5-bit conversion.
// R17: Conversion end sets done bit, stores code, drops enable.
// R18: With audio type 1 cable the converter also decodes keys. The code stops converting once audio type 1 is attached.
// R19: Code 00000 means very low resistance, 11111 floating line.
// R20: Codes rise with resistance from 00001 to 11110.
// R21: Key code starts stuck check; release within 1.5 s restarts identification.
// R22: Stuck key released raises key-recovered then restarts identification.
// R23: Host interrupt low on status change, high once all bits are read.
// R24: Standby samples ID with period set by timing register wake bits.
// R25: Undefined mode code written by host causes no mode change.
`timescale 1ns/10ps
`include "ident_defs.svh"
module mode_ident_core
  import ident_pkg::*;
#(
  parameter int unsigned STUCK_CYCLES = `STUCK_KEY_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Supplies and line status
  input  wire logic       core_supply_ok_in,
  input  wire logic       vbus_present_in,
  input  wire logic       io_supply_in,
  input  wire logic       i2c_hw_reset_in,
  input  wire logic       id_below_1m_in,
  // ID converter
  input  wire logic       conv_done_in,
  input  wire conv_code_t conv_code_in,
  output logic            conv_enable_out,
  // Register port from the I2C slave
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  // Pins and status
  output logic            host_irq_n_out,
  output logic            power_switch_out,
  output logic            charge_level_output_out,
  output logic            charge_level_output_oe_n_out,
  output logic            id_ident_done_out
);

  // ==================================================
  // Helpers
  function automatic logic is_key(input conv_code_t code);
    is_key = (code >= `CODE_KEY_LO) && (code <= `CODE_KEY_HI);
  endfunction : is_key

  function automatic logic [7:0] classify(input conv_code_t code, input logic vbus);
    classify = 8'h00;
    if (code == `CODE_AUDIO1) begin
      classify[`DTYPE_AUDIO1_BIT] = 1'b1;
    end else if (code == `CODE_UART) begin
      classify[`DTYPE_UART_BIT] = 1'b1;
    end else if ((code == `CODE_FLOAT) && vbus) begin
      classify[`DTYPE_SUPPLY_BIT] = 1'b1;
    end
  endfunction : classify

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] ofs);
    hit = (addr == ofs);
  endfunction : hit

  // ==================================================
  // Declarations
  mode_state_t state_reg;
  logic        hold;
  logic        io_prev_reg;
  logic        reset_flag_reg;
  logic        power_save_flag_reg;
  logic        id_open_reg;
  logic        id_open_prev_reg;
  logic [19:0] wake_cnt_reg;
  logic        id_tick;
  logic [7:0]  timing1_reg;
  logic [7:0]  dtype_reg;
  logic [7:0]  int1_reg;
  logic [7:0]  int2_reg;
  logic [4:0]  result_reg;
  logic        conv_flag_reg;
  logic        conv_start;
  logic        conv_done;
  conv_code_t  conv_code;
  logic        key_expired;
  logic        key_start;
  logic        conclude;
  logic [7:0]  conclude_type;
  logic        detach;
  logic        mode_wr;
  logic        force_standby;
  logic        released;
  logic        stuck_set;
  logic        recov_set;

  // Supply absence holds everything but the io supply edge register in reset like the power-on reset
  assign hold = rst_in || !core_supply_ok_in; // R05 R06 R08

  // ==================================================
  // Submodules
  id_conv_ctrl u_conv (
    .clk_in          (clk_in),
    .rst_in          (hold),
    .start_in        (conv_start),
    .conv_done_in    (conv_done_in),
    .conv_code_in    (conv_code_in),
    .conv_enable_out (conv_enable_out),
    .done_out        (conv_done),
    .code_out        (conv_code)
  );

  key_hold_timer #(
    .CYCLES (STUCK_CYCLES)
  ) u_timer (
    .clk_in      (clk_in),
    .rst_in      (hold),
    .start_in    (key_start),
    .run_in      (state_reg == ST_KEY_CHECK),
    .expired_out (key_expired)
  );

  // ==================================================
  // Host mode writes
  assign mode_wr       = reg_wr_in && hit(reg_addr_in, `OFS_MODE_STATUS);
  // Undefined code 10 is dropped, not decoded
  assign force_standby = mode_wr && (reg_wdata_in[1:0] == 2'b00); // R03 R25

  // ==================================================
  // ID sampling: periodic in standby to save current, every cycle otherwise
  always_ff @(posedge clk_in) begin
    if (hold || (state_reg != ST_STANDBY) || id_tick) begin
      wake_cnt_reg <= 20'h0;
    end else begin
      wake_cnt_reg <= wake_cnt_reg + 20'h1;
    end
  end

  assign id_tick = (state_reg != ST_STANDBY) ||
                   (wake_cnt_reg == 20'(({16'h0, timing1_reg[3:0]} + 20'h1) * `WAKE_STEP_CYCLES - 1)); // R24

  always_ff @(posedge clk_in) begin
    if (hold) begin
      id_open_reg      <= 1'b1;
      id_open_prev_reg <= 1'b1;
    end else begin
      if (id_tick) begin
        id_open_reg <= !id_below_1m_in; // R13
      end
      id_open_prev_reg <= id_open_reg;
    end
  end

  // ==================================================
  // Identification events
  assign released  = conv_done && !is_key(conv_code);
  assign key_start = (state_reg == ST_CONV_WAIT) && conv_done && is_key(conv_code); // R18 R21
  assign stuck_set = (state_reg == ST_KEY_CHECK) && key_expired && !released; // R21
  assign recov_set = (state_reg == ST_KEY_STUCK) && released; // R22
  assign conclude  = ((state_reg == ST_CONV_WAIT) && conv_done && !is_key(conv_code)) ||
                     ((state_reg == ST_IDENT) && id_open_reg && vbus_present_in);
  assign conclude_type = (state_reg == ST_IDENT) ? classify(`CODE_FLOAT, vbus_present_in)
                                                 : classify(conv_code, vbus_present_in);
  // With VBUS absent, rising ID-open, or nothing on ID once attached, ends the session
  assign detach    = (state_reg != ST_STANDBY) && id_open_reg && !vbus_present_in &&
                     ((id_open_reg && !id_open_prev_reg) || (state_reg == ST_ATTACHED)); // R14

  // Conversion requests: first one on ID-open fall, repeats while a key is tracked
  assign conv_start = !conv_enable_out && !force_standby && !detach && (
                        ((state_reg == ST_IDENT) && !id_open_reg) || // R14 R16
                        key_start ||
                        (((state_reg == ST_KEY_CHECK) || (state_reg == ST_KEY_STUCK)) &&
                         conv_done && is_key(conv_code)));

  // ==================================================
  // Mode state machine
  always_ff @(posedge clk_in) begin
    if (hold) begin
      state_reg <= ST_STANDBY; // R09
    end else if (force_standby || detach) begin
      state_reg <= ST_STANDBY; // R03
    end else begin
      case (state_reg)
        ST_STANDBY: begin
          // Level watch also restarts after a forced standby
          if (vbus_present_in || !id_open_reg) begin
            state_reg <= ST_IDENT; // R04 R07 R10
          end
        end
        ST_IDENT: begin
          if (!id_open_reg) begin
            state_reg <= ST_CONV_WAIT;
          end else if (vbus_present_in) begin
            state_reg <= ST_ATTACHED;
          end
        end
        ST_CONV_WAIT: begin
          if (key_start) begin
            state_reg <= ST_KEY_CHECK; // R21
          end else if (conclude) begin
            state_reg <= ST_ATTACHED;
          end
        end
        ST_KEY_CHECK: begin
          if (released) begin
            state_reg <= ST_IDENT; // R21
          end else if (stuck_set) begin
            state_reg <= ST_KEY_STUCK;
          end
        end
        ST_KEY_STUCK: begin
          if (recov_set) begin
            state_reg <= ST_IDENT; // R22
          end
        end
        ST_ATTACHED: begin
          state_reg <= ST_ATTACHED;
        end
        default: begin
          state_reg <= ST_STANDBY;
        end
      endcase
    end
  end

  // ==================================================
  // Power save bit: only meaningful while a session is active
  always_ff @(posedge clk_in) begin
    if (hold || force_standby || detach || (state_reg == ST_STANDBY)) begin
      power_save_flag_reg <= 1'b0;
    end else if (mode_wr && reg_wdata_in[`MODE_ACTIVE_BIT]) begin
      power_save_flag_reg <= reg_wdata_in[`MODE_POWER_SAVE_FLAG_BIT]; // R02 R03
    end
  end

  // ==================================================
  // Reset-occurred flag; a new reset event wins over the read clear
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      io_prev_reg <= 1'b0;
    end else begin
      io_prev_reg <= io_supply_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (hold || i2c_hw_reset_in || (io_prev_reg && !io_supply_in)) begin
      reset_flag_reg <= 1'b1; // R01
    end else if (reg_rd_in && hit(reg_addr_in, `OFS_MODE_STATUS)) begin
      reset_flag_reg <= 1'b0; // R01
    end
  end

  // ==================================================
  // Timing register
  always_ff @(posedge clk_in) begin
    if (hold) begin
      timing1_reg <= `TIMING1_RST; // R08
    end else if (reg_wr_in && hit(reg_addr_in, `OFS_TIMING1)) begin
      timing1_reg <= reg_wdata_in;
    end
  end

  // ==================================================
  // Device type and converter result
  always_ff @(posedge clk_in) begin
    if (hold || detach || force_standby) begin
      dtype_reg <= 8'h00;
    end else if (conclude) begin
      dtype_reg <= conclude_type; // R11
    end
  end

  always_ff @(posedge clk_in) begin
    if (hold) begin
      result_reg <= 5'h00;
    end else if (conv_done) begin
      result_reg <= conv_code; // R17 R19 R20
    end
  end

  always_ff @(posedge clk_in) begin
    if (hold) begin
      conv_flag_reg <= 1'b0;
    end else if (conv_done) begin
      conv_flag_reg <= 1'b1; // R17
    end else if (reg_rd_in && hit(reg_addr_in, `OFS_CONV_RESULT)) begin
      conv_flag_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk_in) begin
    if (hold) begin
      id_ident_done_out <= 1'b0;
    end else begin
      id_ident_done_out <= conclude; // R15
    end
  end

  // ==================================================
  // Interrupt bits are read-clear; a same-cycle event survives the read
  always_ff @(posedge clk_in) begin
    if (hold) begin
      int1_reg <= 8'h00;
    end else begin
      if (reg_rd_in && hit(reg_addr_in, `OFS_INT1)) begin
        int1_reg <= 8'h00;
      end
      if (conclude) begin
        int1_reg[`INT1_ATTACH_BIT] <= 1'b1; // R11
      end
      if (detach && (state_reg == ST_ATTACHED)) begin
        int1_reg[`INT1_DETACH_BIT] <= 1'b1; // R14
      end
      if (stuck_set) begin
        int1_reg[`INT1_STUCK_BIT] <= 1'b1; // R21
      end
      if (recov_set) begin
        int1_reg[`INT1_RECOV_BIT] <= 1'b1; // R22
      end
    end
  end

  always_ff @(posedge clk_in) begin
    if (hold) begin
      int2_reg <= 8'h00;
    end else if (conclude && (conclude_type == 8'h00)) begin
      int2_reg[`INT2_UNKNOWN_BIT] <= 1'b1; // R12
    end else if (reg_rd_in && hit(reg_addr_in, `OFS_INT2)) begin
      int2_reg <= 8'h00;
    end
  end

  // Pin follows the bits one cycle later
  always_ff @(posedge clk_in) begin
    if (hold) begin
      host_irq_n_out <= 1'b1;
    end else begin
      host_irq_n_out <= !((|int1_reg) || (|int2_reg)); // R23
    end
  end

  // ==================================================
  // Power switch and charge level pin
  always_ff @(posedge clk_in) begin
    if (hold) begin
      power_switch_out <= vbus_present_in; // R05 R08
    end else begin
      power_switch_out <= vbus_present_in && (state_reg != ST_STANDBY); // R09
    end
  end

  always_ff @(posedge clk_in) begin
    charge_level_output_out <= 1'b0;
    if (hold) begin
      charge_level_output_oe_n_out <= 1'b1; // R05 R06
    end else begin
      charge_level_output_oe_n_out <= !((state_reg == ST_ATTACHED) && dtype_reg[`DTYPE_SUPPLY_BIT]);
    end
  end

  // ==================================================
  // Register read port
  always_ff @(posedge clk_in) begin
    if (hold) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      case (reg_addr_in)
        `OFS_DEVICE_TYPE: reg_rdata_out <= dtype_reg;
        `OFS_MODE_STATUS: begin
          reg_rdata_out <= {5'h00, reset_flag_reg, power_save_flag_reg, (state_reg != ST_STANDBY)}; // R02
        end
        `OFS_INT1:        reg_rdata_out <= int1_reg;
        `OFS_INT2:        reg_rdata_out <= int2_reg;
        `OFS_CONV_RESULT: reg_rdata_out <= {3'h0, result_reg};
        `OFS_ID_STATUS:   reg_rdata_out <= {6'h00, conv_flag_reg, id_open_reg};
        `OFS_TIMING1:     reg_rdata_out <= timing1_reg;
        default:          reg_rdata_out <= 8'h00;
      endcase
    end
  end

endmodule : mode_ident_core

// File: dv/id_converter_model.sv
`timescale 1ns/10ps
module id_converter_model
  import ident_pkg::*;
(
  // Clock and reset
  input  wire logic       clk_in,
  input  wire logic       rst_in,
  // Converter handshake
  input  wire logic       enable_in,
  input  wire conv_code_t level_in,
  input  wire logic [3:0] delay_in,
  output logic            done_out,
  output conv_code_t      code_out
);
  logic [3:0] cnt_reg;
  conv_code_t last_reg;

  // ==========
  // Conversion
  // Off the done cycle the code shows the inverse of the last result, so a late latch is caught
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      cnt_reg  <= 4'h0;
      done_out <= 1'b0;
      last_reg <= 5'h00;
      code_out <= 5'h1f;
    end else begin
      done_out <= 1'b0;
      code_out <= ~last_reg;
      if (enable_in && !done_out) begin
        if (cnt_reg >= delay_in) begin
          done_out <= 1'b1;
          code_out <= level_in;
          last_reg <= level_in;
          cnt_reg  <= 4'h0;
        end else begin
          cnt_reg <= cnt_reg + 4'h1;
        end
      end else begin
        cnt_reg <= 4'h0;
      end
    end
  end
endmodule : id_converter_model

// File: dv/mode_ident_core_monitor.sv
`timescale 1ns/10ps
`include "ident_defs.svh"
module mode_ident_core_monitor
  import ident_pkg::*;
#(
  parameter int unsigned STUCK_CYCLES = 50
) (
  // Clock and reset
  input wire logic       clk_in,
  input wire logic       rst_in,
  // Core inputs
  input wire logic       core_supply_ok_in,
  input wire logic       vbus_present_in,
  input wire logic       io_supply_in,
  input wire logic       i2c_hw_reset_in,
  input wire logic       id_below_1m_in,
  input wire logic       conv_done_in,
  input wire conv_code_t conv_code_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  // Core outputs
  input wire logic       conv_enable_out,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       host_irq_n_out,
  input wire logic       power_switch_out,
  input wire logic       charge_level_output_out,
  input wire logic       charge_level_output_oe_n_out,
  input wire logic       id_ident_done_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (rst_in || !core_supply_ok_in);

  // ==========
  // Sequences
  sequence conv_hit;
    conv_enable_out && conv_done_in;
  endsequence
  sequence ident_end;
    id_ident_done_out;
  endsequence

  // ==========
  // Checks
  a_enable_self_clear: assert property (conv_hit |=> !conv_enable_out)
    else $error("conversion enable stayed high after done");
  a_enable_holds: assert property (conv_enable_out && !conv_done_in |=> conv_enable_out)
    else $error("conversion enable dropped before done");
  a_done_one_pulse: assert property (ident_end |=> !id_ident_done_out)
    else $error("ident done longer than one cycle");
  a_irq_after_ident: assert property (ident_end |=> !host_irq_n_out)
    else $error("host interrupt not low after identification");
  a_switch_follows_vbus: assert property (disable iff (rst_in)
    !core_supply_ok_in |=> power_switch_out == $past(vbus_present_in))
    else $error("power switch not following vbus without core supply");
  a_charge_output_open: assert property (disable iff (rst_in)
    !core_supply_ok_in |=> charge_level_output_oe_n_out)
    else $error("charge level output driven without core supply");
  a_reset_values_out: assert property (disable iff (rst_in)
    $fell(rst_in) |-> host_irq_n_out && !conv_enable_out && !id_ident_done_out && reg_rdata_out == 8'h00)
    else $error("outputs not at reset values after reset");
  a_mode_code_defined: assert property (reg_rd_in && reg_addr_in == `OFS_MODE_STATUS
    |=> reg_rdata_out[1:0] != 2'b10)
    else $error("undefined mode code read back");
endmodule : mode_ident_core_monitor

bind mode_ident_core mode_ident_core_monitor #(.STUCK_CYCLES(STUCK_CYCLES)) i_mode_ident_core_monitor (
  .clk_in, .rst_in, .core_supply_ok_in, .vbus_present_in, .io_supply_in, .i2c_hw_reset_in,
  .id_below_1m_in, .conv_done_in, .conv_code_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in,
  .conv_enable_out, .reg_rdata_out, .host_irq_n_out, .power_switch_out, .charge_level_output_out,
  .charge_level_output_oe_n_out, .id_ident_done_out);

// File: dv/test_mode_ident_core.sv
`timescale 1ns/10ps
`include "ident_defs.svh"
module test_mode_ident_core
  import ident_pkg::*;
;
  localparam int unsigned STUCK = 50;
  logic clk_in, rst_in, core_supply_ok_in, vbus_present_in, io_supply_in, i2c_hw_reset_in, id_below_1m_in;
  logic conv_done_in, conv_enable_out, reg_wr_in, reg_rd_in, host_irq_n_out, power_switch_out;
  logic charge_level_output_out, charge_level_output_oe_n_out, id_ident_done_out;
  logic [7:0] reg_addr_in, reg_wdata_in, reg_rdata_out;
  conv_code_t conv_code_in, code_sel, c;
  conv_code_t codes [4];
  logic [3:0] delay;
  logic [31:0] seed;
  int fail_count, checked, cycles;

  mode_ident_core #(.STUCK_CYCLES(STUCK)) i_mode_ident_core (
    .clk_in, .rst_in, .core_supply_ok_in, .vbus_present_in, .io_supply_in, .i2c_hw_reset_in,
    .id_below_1m_in, .conv_done_in, .conv_code_in, .conv_enable_out, .reg_addr_in, .reg_wr_in,
    .reg_rd_in, .reg_wdata_in, .reg_rdata_out, .host_irq_n_out, .power_switch_out,
    .charge_level_output_out, .charge_level_output_oe_n_out, .id_ident_done_out);
  id_converter_model i_id_converter_model (.clk_in, .rst_in, .enable_in(conv_enable_out),
    .level_in(code_sel), .delay_in(delay), .done_out(conv_done_in), .code_out(conv_code_in));

  // ==========
  // Clock and watchdog
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 100000) begin
      fail_count++;
      final_report();
    end
  end

  // ==========
  // Reference model and helpers
  function automatic logic [31:0] xs(input logic [31:0] s);
    s = s ^ (s << 13);
    s = s ^ (s >> 17);
    s = s ^ (s << 5);
    return s;
  endfunction : xs
  function automatic logic [7:0] dtype_of(input conv_code_t k);
    return (k == `CODE_UART) ? 8'h04 : (k == `CODE_AUDIO1) ? 8'h02 : 8'h00;
  endfunction : dtype_of
  task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp, input string what);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_rd_in = 1'b1;
    @(negedge clk_in);
    reg_rd_in = 1'b0;
    @(negedge clk_in);
    check(what, exp, reg_rdata_out);
  endtask : rd_chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(negedge clk_in);
    reg_addr_in = a;
    reg_wdata_in = v;
    reg_wr_in = 1'b1;
    @(negedge clk_in);
    reg_wr_in = 1'b0;
  endtask : wr_reg
  // Bounded wait: 0 ident done, 1 conversion request, 2 interrupt low
  task automatic wait_pin(input int which);
    for (int k = 0; k < 20000; k++) begin
      @(negedge clk_in);
      if ((which == 0 && id_ident_done_out === 1'b1) || (which == 1 && conv_enable_out === 1'b1) ||
          (which == 2 && host_irq_n_out === 1'b0)) return;
    end
    fail_count++;
    $display("[FAIL] wait %0d expected 1 seen 0", which);
  endtask : wait_pin
  task automatic detach();
    id_below_1m_in = 1'b0;
    wait_pin(2);
    rd_chk(`OFS_INT1, 8'h02, "int1_detach");
  endtask : detach
  task automatic key_press(input int hold);
    code_sel = 5'h01 + conv_code_t'(seed % 12);
    seed = xs(seed);
    id_below_1m_in = 1'b1;
    wait_pin(1);
    repeat (hold) @(negedge clk_in);
  endtask : key_press
  task final_report();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : final_report

  // ==========
  // Main sequence
  initial begin
    {rst_in, vbus_present_in, io_supply_in} = 3'b111;
    {core_supply_ok_in, i2c_hw_reset_in, id_below_1m_in, reg_wr_in, reg_rd_in} = 5'h00;
    {reg_addr_in, reg_wdata_in} = 16'h0000;
    code_sel = `CODE_UART;
    delay = 4'h2;
    seed = 32'h3f825141;
    repeat (8) @(negedge clk_in);
    check("power_switch", 8'h01, {7'h00, power_switch_out});
    check("charge_oe_n", 8'h01, {7'h00, charge_level_output_oe_n_out});
    core_supply_ok_in = 1'b1;
    rst_in = 1'b0;
    wait_pin(0);
    rd_chk(`OFS_MODE_STATUS, 8'h05, "mode");
    rd_chk(`OFS_MODE_STATUS, 8'h01, "mode");
    rd_chk(`OFS_DEVICE_TYPE, 8'h01, "device_type");
    rd_chk(`OFS_INT1, 8'h01, "int1");
    rd_chk(`OFS_INT2, 8'h00, "int2");
    check("irq_n", 8'h01, {7'h00, host_irq_n_out});
    io_supply_in = 1'b0;
    @(negedge clk_in);
    io_supply_in = 1'b1;
    rd_chk(`OFS_MODE_STATUS, 8'h05, "mode");
    i2c_hw_reset_in = 1'b1;
    @(negedge clk_in);
    i2c_hw_reset_in = 1'b0;
    rd_chk(`OFS_MODE_STATUS, 8'h05, "mode");
    wr_reg(`OFS_MODE_STATUS, 8'h03);
    rd_chk(`OFS_MODE_STATUS, 8'h03, "mode");
    wr_reg(`OFS_MODE_STATUS, 8'h02);
    rd_chk(`OFS_MODE_STATUS, 8'h03, "mode");
    wr_reg(`OFS_MODE_STATUS, 8'h01);
    rd_chk(`OFS_MODE_STATUS, 8'h01, "mode");
    wr_reg(`OFS_MODE_STATUS, 8'h00);
    wait_pin(0);
    rd_chk(`OFS_INT1, 8'h01, "int1");
    wr_reg(`OFS_TIMING1, 8'ha5);
    rd_chk(`OFS_TIMING1, 8'ha5, "timing1");
    wr_reg(`OFS_TIMING1, 8'h00);
    wr_reg(8'h00, 8'hff);
    rd_chk(8'h00, 8'h00, "unmapped");
    vbus_present_in = 1'b0;
    wait_pin(2);
    rd_chk(`OFS_INT1, 8'h02, "int1_detach");
    codes = '{`CODE_UART, `CODE_AUDIO1, 5'h1e, 5'h0d + conv_code_t'(seed[2:0])};
    foreach (codes[i]) begin
      c = codes[i];
      code_sel = c;
      delay = {1'b0, seed[2:0]};
      seed = xs(seed);
      id_below_1m_in = 1'b1;
      wait_pin(0);
      rd_chk(`OFS_ID_STATUS, 8'h02, "status");
      rd_chk(`OFS_CONV_RESULT, {3'h0, c}, "result");
      rd_chk(`OFS_DEVICE_TYPE, dtype_of(c), "device_type");
      rd_chk(`OFS_INT2, (dtype_of(c) == 8'h00) ? 8'h01 : 8'h00, "int2");
      rd_chk(`OFS_INT1, 8'h01, "int1");
      check("irq_n", 8'h01, {7'h00, host_irq_n_out});
      detach();
    end
    // Short press: released well inside the hold time
    key_press(10);
    code_sel = `CODE_UART;
    wait_pin(0);
    rd_chk(`OFS_INT1, 8'h01, "int1");
    detach();
    // Long press: stuck, then released
    key_press(0);
    wait_pin(2);
    rd_chk(`OFS_INT1, 8'h04, "int1_stuck");
    code_sel = `CODE_AUDIO1;
    wait_pin(0);
    rd_chk(`OFS_INT1, 8'h09, "int1_recovered");
    rd_chk(`OFS_DEVICE_TYPE, 8'h02, "device_type");
    detach();
    // Core supply dropout with VBUS present
    vbus_present_in = 1'b1;
    core_supply_ok_in = 1'b0;
    repeat (3) @(negedge clk_in);
    check("drop", 8'h03, {5'h00, charge_level_output_out, power_switch_out, charge_level_output_oe_n_out});
    core_supply_ok_in = 1'b1;
    wait_pin(0);
    rd_chk(`OFS_MODE_STATUS, 8'h05, "mode");
    final_report();
  end
endmodule : test_mode_ident_core

// File: include/ident_defs.svh
`ifndef IDENT_DEFS_SVH
`define IDENT_DEFS_SVH

// ==================================================
// Register offsets
`define OFS_DEVICE_TYPE   8'h01
`define OFS_MODE_STATUS   8'h02
`define OFS_INT1          8'h03
`define OFS_INT2          8'h04
`define OFS_CONV_RESULT   8'h05
`define OFS_ID_STATUS     8'h06
`define OFS_TIMING1       8'h07

// ==================================================
// Field positions
`define MODE_ACTIVE_BIT   0
`define MODE_POWER_SAVE_FLAG_BIT    1
`define MODE_RESET_BIT    2
`define INT1_ATTACH_BIT   0
`define INT1_DETACH_BIT   1
`define INT1_STUCK_BIT    2
`define INT1_RECOV_BIT    3
`define INT2_UNKNOWN_BIT  0
`define STAT_ID_OPEN_BIT  0
`define STAT_CONV_BIT     1
`define DTYPE_SUPPLY_BIT  0
`define DTYPE_AUDIO1_BIT  1
`define DTYPE_UART_BIT    2

// ==================================================
// Reset values and codes
`define TIMING1_RST       8'h00
`define CODE_LOW_R        5'h00
`define CODE_FLOAT        5'h1f
`define CODE_AUDIO1       5'h1a
`define CODE_UART         5'h16
`define CODE_KEY_LO       5'h01
`define CODE_KEY_HI       5'h0c

// ==================================================
// Timing
`define CLK_KHZ           40000
`define STUCK_TIME_MS     1500
`define STUCK_KEY_CYCLES  (`STUCK_TIME_MS * `CLK_KHZ)
`define WAKE_STEP_CYCLES  4000

`endif

// File: include/ident_pkg.sv
package ident_pkg;

  typedef enum logic [5:0] {
    ST_STANDBY   = 6'h01,
    ST_IDENT     = 6'h02,
    ST_CONV_WAIT = 6'h04,
    ST_ATTACHED  = 6'h08,
    ST_KEY_CHECK = 6'h10,
    ST_KEY_STUCK = 6'h20
  } mode_state_t;

  typedef logic [4:0] conv_code_t;

endpackage : ident_pkg
